// *** dv/tb_aux_channel_motion_detect_regs.sv ***
/*
 Self-checking bench for the aux-channel motion detect register bank:
 APB master tasks, a temperature sample driver and one task per scenario.
 Assumes amd_pkg is compiled first and that the bank answers APB with pready.
*/
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin \
  $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); error_cnt++; end end

module tb_aux_channel_motion_detect_regs;
  import amd_pkg::*;

  logic                  clk_sys;
  logic                  reset;
  logic                  clk_en;
  amd_apb_req_t          apb_req;
  amd_aux_sample_t       temp_sample;
  logic                  reg_upset;
  logic                  soft_reset_done;
  logic                  pready;
  logic [AMD_DATA_W-1:0] prdata;
  logic                  pslverr;
  logic                  aux_activity_event;
  logic                  aux_inactivity_event;
  logic                  awake;
  logic [2:0]            axis_check_enable;
  logic [1:0]            tap_axis_select;
  logic                  ext_converter_active;
  logic                  upset_error;
  logic                  irq;
  int                    error_cnt = 0;
  int                    compares  = 0;
  int                    cyc       = 0;

  // Ext source left idle: only the temperature path carries samples here
  amd_regs uut (
    .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .apb_req(apb_req),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .temp_sample(temp_sample), .ext_sample('0), .reg_upset(reg_upset),
    .soft_reset_done(soft_reset_done), .aux_activity_event(aux_activity_event),
    .aux_inactivity_event(aux_inactivity_event), .awake(awake),
    .axis_check_enable(axis_check_enable), .tap_axis_select(tap_axis_select),
    .ext_converter_active(ext_converter_active), .upset_error(upset_error),
    .irq(irq)
  );

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic print_verdict;
    if (error_cnt == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  // Generous ceiling; the full run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 4000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk_sys);
    apb_req.psel    <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite  <= wr;
    apb_req.paddr   <= {2'h0, idx, 2'h0};
    apb_req.pwdata  <= wd;
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    `CHK("pready", 1'b1, pready)
    rd  = prdata;
    err = pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, d, r, e);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, idx, 32'h0, r, e);
    `CHK(nm, exp, r)
  endtask : rd_chk

  // One-cycle sample; events are looked at in the cycle after it is taken
  task automatic samp(input logic [13:0] c, output logic a, output logic i);
    @(posedge clk_sys);
    temp_sample <= '{valid: 1'b1, code: c};
    @(posedge clk_sys);
    temp_sample.valid <= 1'b0;
    #1;
    a = aux_activity_event;
    i = aux_inactivity_event;
  endtask : samp

  task automatic run(input string nm, input logic act_kind, input logic ev_last,
                     input logic [13:0] c[$]);
    logic a;
    logic i;
    foreach (c[k]) begin
      samp(c[k], a, i);
      `CHK(nm, (k == c.size() - 1) ? ev_last : 1'b0, act_kind ? a : i)
    end
  endtask : run

  task automatic t_reset;
    `CHK("awake", 1'b1, awake)
    `CHK("axis_en", 3'h7, axis_check_enable)
    `CHK("irq", 1'b0, irq)
    rd_chk("thr_low", AMD_IDX_THR_LOW, 32'h0);
    rd_chk("timers", AMD_IDX_TIMERS, 32'h0);
    rd_chk("axis", AMD_IDX_AXIS, 32'h0);
    rd_chk("mirror", AMD_IDX_MIRROR, 32'hC0);
    `CHK("upset", 1'b1, upset_error)
  endtask : t_reset

  task automatic t_regs;
    wr(AMD_IDX_MIRROR, 32'hFF);
    rd_chk("mirror", AMD_IDX_MIRROR, 32'h40);
    `CHK("upset", 1'b0, upset_error)
    wr(AMD_IDX_THR_LOW, 32'hFF);
    rd_chk("thr_low", AMD_IDX_THR_LOW, 32'hFC);
    wr(AMD_IDX_TIMERS, 32'h32);
    rd_chk("timers", AMD_IDX_TIMERS, 32'h32);
  endtask : t_regs

  task automatic t_axis;
    for (int k = 0; k < 3; k++) begin
      wr(AMD_IDX_AXIS, (32'h10 * k) | (32'h1 << k));
      rd_chk("axis", AMD_IDX_AXIS, (32'h10 * k) | (32'h1 << k));
      `CHK("tap", k[1:0], tap_axis_select)
      `CHK("axis_en", ~(3'h1 << k), axis_check_enable)
    end
    wr(AMD_IDX_AXIS, 32'hFF);
    rd_chk("axis", AMD_IDX_AXIS, 32'h37);
    `CHK("tap", 2'h0, tap_axis_select)
    wr(AMD_IDX_AXIS, 32'h0);
  endtask : t_axis

  task automatic t_motion;
    wr(AMD_IDX_THR_LOW, 32'h28);
    wr(AMD_IDX_INACT_THR_H, 32'h0);
    wr(AMD_IDX_ACT_THR, 32'h64);
    wr(AMD_IDX_IRQ_MASK, 32'h3);
    wr(AMD_IDX_IRQ_STAT, 32'h7);
    wr(AMD_IDX_AUX_CTRL, 32'h10B);
    run("act_ev", 1'b1, 1'b1, '{14'h00C8, 14'h3F9C, 14'h00C8, 14'h3ED4});
    `CHK("irq", 1'b1, irq)
    rd_chk("irq_stat", AMD_IDX_IRQ_STAT, 32'h1);
    wr(AMD_IDX_IRQ_STAT, 32'h1);
    rd_chk("irq_stat", AMD_IDX_IRQ_STAT, 32'h0);
    `CHK("irq", 1'b0, irq)
    run("inact_ev", 1'b0, 1'b1,
        '{14'h0005, 14'h3FFB, 14'h3FF6, 14'h0005, 14'h3FFB, 14'h0005});
    rd_chk("mirror", AMD_IDX_MIRROR, 32'h0);
    `CHK("awake", 1'b0, awake)
    `CHK("irq", 1'b1, irq)
    wr(AMD_IDX_AUX_CTRL, 32'h30B);
    run("act_ev", 1'b1, 1'b1, '{14'h00C8, 14'h00C8});
    rd_chk("mirror", AMD_IDX_MIRROR, 32'h40);
    wr(AMD_IDX_AUX_CTRL, 32'h00B);
    run("inact_ev", 1'b0, 1'b1, '{14'h0005, 14'h0005, 14'h0005});
    rd_chk("mirror", AMD_IDX_MIRROR, 32'h40);
    wr(AMD_IDX_AUX_CTRL, 32'h003);
    run("inact_off", 1'b0, 1'b0, '{14'h0005, 14'h0005, 14'h0005});
    wr(AMD_IDX_AUX_CTRL, 32'h009);
    run("act_off", 1'b1, 1'b0, '{14'h00C8, 14'h00C8});
  endtask : t_motion

  task automatic t_ext;
    wr(AMD_IDX_AUX_CTRL, 32'h011);
    rd_chk("ctrl", AMD_IDX_AUX_CTRL, 32'h011);
    `CHK("ext_on", 1'b0, ext_converter_active)
    wr(AMD_IDX_AUX_CTRL, 32'h010);
    rd_chk("ctrl", AMD_IDX_AUX_CTRL, 32'h010);
    `CHK("ext_on", 1'b1, ext_converter_active)
  endtask : t_ext

  task automatic t_upset;
    logic [31:0] r;
    logic        e;
    @(posedge clk_sys);
    reg_upset <= 1'b1;
    @(posedge clk_sys);
    reg_upset <= 1'b0;
    rd_chk("mirror", AMD_IDX_MIRROR, 32'hC0);
    wr(AMD_IDX_TIMERS, 32'h32);
    rd_chk("mirror", AMD_IDX_MIRROR, 32'h40);
    @(posedge clk_sys);
    soft_reset_done <= 1'b1;
    @(posedge clk_sys);
    soft_reset_done <= 1'b0;
    rd_chk("mirror", AMD_IDX_MIRROR, 32'hC0);
    apb(1'b0, 8'h50, 32'h0, r, e);
    `CHK("pslverr", 1'b1, e)
    `CHK("prdata", 32'h0, r)
  endtask : t_upset

  // Samples offered while frozen must not count towards a run
  task automatic t_freeze;
    wr(AMD_IDX_AUX_CTRL, 32'h00B);
    clk_en <= 1'b0;
    run("act_frozen", 1'b1, 1'b0, '{14'h00C8, 14'h00C8});
    @(posedge clk_sys);
    clk_en <= 1'b1;
    run("act_thawed", 1'b1, 1'b1, '{14'h00C8, 14'h00C8});
  endtask : t_freeze

  // Mid-run reset must bring back the power-on picture
  task automatic t_rst2;
    `CHK("irq", 1'b1, irq)
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    rd_chk("timers", AMD_IDX_TIMERS, 32'h0);
    rd_chk("ctrl", AMD_IDX_AUX_CTRL, 32'h0);
    rd_chk("irq_stat", AMD_IDX_IRQ_STAT, 32'h4);
    rd_chk("mirror", AMD_IDX_MIRROR, 32'hC0);
    `CHK("irq", 1'b0, irq)
    `CHK("awake", 1'b1, awake)
    `CHK("axis_en", 3'h7, axis_check_enable)
    `CHK("tap", 2'h0, tap_axis_select)
  endtask : t_rst2

  initial begin
    reset           = 1'b1;
    clk_en          = 1'b1;
    apb_req         = '0;
    temp_sample     = '0;
    reg_upset       = 1'b0;
    soft_reset_done = 1'b0;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    t_reset();
    t_regs();
    t_axis();
    t_motion();
    t_ext();
    t_upset();
    t_freeze();
    t_rst2();
    print_verdict();
  end

endmodule : tb_aux_channel_motion_detect_regs

// *** hdl/amd_pkg.sv ***
/*
 Constants, register map and carrier types for the auxiliary-channel motion
 detect register bank. Assumes one clock domain and an APB master outside.
*/
package amd_pkg;

  localparam int AMD_ADDR_W = 12;
  localparam int AMD_DATA_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [7:0] AMD_IDX_THR_LOW     = 8'h41;
  localparam logic [7:0] AMD_IDX_TIMERS      = 8'h42;
  localparam logic [7:0] AMD_IDX_AXIS        = 8'h43;
  localparam logic [7:0] AMD_IDX_MIRROR      = 8'h44;
  localparam logic [7:0] AMD_IDX_AUX_CTRL    = 8'h48;
  localparam logic [7:0] AMD_IDX_ACT_THR     = 8'h49;
  localparam logic [7:0] AMD_IDX_INACT_THR_H = 8'h4A;
  localparam logic [7:0] AMD_IDX_IRQ_STAT    = 8'h4B;
  localparam logic [7:0] AMD_IDX_IRQ_MASK    = 8'h4C;

  // Field positions
  localparam int AMD_THR_LOW_LSB   = 2;
  localparam int AMD_TMR_INACT_LSB = 4;
  localparam int AMD_TMR_ACT_LSB   = 0;
  localparam int AMD_TAP_AXIS_LSB  = 4;
  localparam int AMD_UPSET_BIT     = 7;
  localparam int AMD_AWAKE_BIT     = 6;
  localparam int AMD_CTL_TEMP_EN   = 0;
  localparam int AMD_CTL_TEMP_ACT  = 1;
  localparam int AMD_CTL_TEMP_INACT = 3;
  localparam int AMD_CTL_EXT_EN    = 4;
  localparam int AMD_CTL_EXT_ACT   = 5;
  localparam int AMD_CTL_EXT_INACT = 6;
  localparam int AMD_CTL_MODE_LSB  = 8;
  localparam int AMD_IRQ_ACT       = 0;
  localparam int AMD_IRQ_INACT     = 1;
  localparam int AMD_IRQ_UPSET     = 2;

  // Reset values
  localparam logic [7:0]  AMD_RST_THR_LOW  = 8'h00;
  localparam logic [7:0]  AMD_RST_TIMERS   = 8'h00;
  localparam logic [7:0]  AMD_RST_AXIS     = 8'h00;
  localparam logic [7:0]  AMD_RST_MIRROR   = 8'h40;
  localparam logic [9:0]  AMD_RST_AUX_CTRL = 10'h000;
  localparam logic [12:0] AMD_RST_ACT_THR  = 13'h0000;
  localparam logic [6:0]  AMD_RST_INACT_H  = 7'h00;
  localparam logic [2:0]  AMD_RST_IRQ      = 3'h0;

  typedef enum logic [1:0] {
    AMD_SEQ_DEFAULT = 2'h0,
    AMD_SEQ_LINKED  = 2'h1,
    AMD_SEQ_LOOP    = 2'h3
  } amd_seq_mode_t;

  typedef enum logic {
    AMD_BUS_IDLE = 1'b0,
    AMD_BUS_RESP = 1'b1
  } amd_bus_state_t;

  typedef struct packed {
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [AMD_ADDR_W-1:0] paddr;
    logic [AMD_DATA_W-1:0] pwdata;
  } amd_apb_req_t;

  typedef struct packed {
    logic        valid;
    logic [13:0] code;
  } amd_aux_sample_t;

endpackage : amd_pkg

// *** hdl/amd_regs.sv ***
/*
 Auxiliary-channel motion detect register bank: APB slave, aux activity and
 inactivity run counters, awake state, upset flag and interrupt.
 Assumes samples and upset pulses are synchronous to clk_sys, one cycle each.
*/
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns
module amd_regs (
  input  wire logic                        clk_sys,
  input  wire logic                        reset,
  input  wire logic                        clk_en,
  input  wire amd_pkg::amd_apb_req_t       apb_req,
  output logic                             pready,
  output logic [amd_pkg::AMD_DATA_W-1:0]   prdata,
  output logic                             pslverr,
  input  wire amd_pkg::amd_aux_sample_t    temp_sample,
  input  wire amd_pkg::amd_aux_sample_t    ext_sample,
  input  wire logic                        reg_upset,
  input  wire logic                        soft_reset_done,
  output logic                             aux_activity_event,
  output logic                             aux_inactivity_event,
  output logic                             awake,
  output logic [2:0]                       axis_check_enable,
  output logic [1:0]                       tap_axis_select,
  output logic                             ext_converter_active,
  output logic                             upset_error,
  output logic                             irq
);
  import amd_pkg::*;

  amd_bus_state_t bus_state_reg, bus_state_next;
  logic [5:0]  thr_low_reg, thr_low_next;
  logic [7:0]  timers_reg, timers_next;
  logic [5:0]  axis_reg, axis_next;
  logic [9:0]  ctrl_reg, ctrl_next;
  logic [12:0] act_thr_reg, act_thr_next;
  logic [6:0]  inact_h_reg, inact_h_next;
  logic [2:0]  irq_stat_reg, irq_stat_next;
  logic [2:0]  irq_mask_reg, irq_mask_next;
  logic [3:0]  act_run_reg, act_run_next;
  logic [3:0]  inact_run_reg, inact_run_next;
  logic        upset_reg, upset_next;
  logic        unconf_reg, unconf_next;
  logic        awake_reg, awake_next;
  logic        act_evt_reg, act_evt_next;
  logic        inact_evt_reg, inact_evt_next;
  logic        pready_reg, pready_next;
  logic        pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        irq_reg, irq_next;
  logic        ext_on_reg, ext_on_next;
  logic [2:0]  axis_en_reg, axis_en_next;
  logic [1:0]  tap_reg, tap_next;

  logic            wr_acc;
  logic [31:0]     wd;
  amd_aux_sample_t smp;
  logic            act_en, inact_en;
  logic [13:0]     mag;
  logic [12:0]     inact_thr;
  logic [2:0]      irq_set;

  function automatic logic idx_hit(input logic [AMD_ADDR_W-1:0] addr,
                                   input logic [7:0] idx);
    idx_hit = (addr[AMD_ADDR_W-1:2] == {2'h0, idx});
  endfunction : idx_hit

  function automatic logic [13:0] magnitude(input logic [13:0] code);
    magnitude = code[13] ? 14'((~code) + 14'h0001) : code;
  endfunction : magnitude

  function automatic logic [3:0] run_step(input logic [3:0] run);
    run_step = (run == 4'hF) ? run : 4'(run + 4'h1);
  endfunction : run_step

  // Count before this sample; a saturated run wraps here so it never fires twice
  function automatic logic run_done(input logic [3:0] run, input logic [3:0] tmr);
    run_done = (4'(run + 4'h1) == ((tmr == 4'h0) ? 4'h1 : tmr));
  endfunction : run_done

  function automatic logic mapped(input logic [AMD_ADDR_W-1:0] a);
    mapped = idx_hit(a, AMD_IDX_THR_LOW) | idx_hit(a, AMD_IDX_TIMERS)
           | idx_hit(a, AMD_IDX_AXIS) | idx_hit(a, AMD_IDX_MIRROR)
           | idx_hit(a, AMD_IDX_AUX_CTRL) | idx_hit(a, AMD_IDX_ACT_THR)
           | idx_hit(a, AMD_IDX_INACT_THR_H) | idx_hit(a, AMD_IDX_IRQ_STAT)
           | idx_hit(a, AMD_IDX_IRQ_MASK);
  endfunction : mapped

  // Bus handshake: one wait state, so pready and prdata come from flops
  always_comb begin
    bus_state_next = bus_state_reg;
    pready_next    = 1'b0;
    pslverr_next   = 1'b0;
    prdata_next    = prdata_reg;
    case (bus_state_reg)
      AMD_BUS_IDLE: begin
        if (apb_req.psel && apb_req.penable) begin
          bus_state_next = AMD_BUS_RESP;
          pready_next    = 1'b1;
          pslverr_next   = ~mapped(apb_req.paddr);
          prdata_next    = 32'h0000_0000;
          if (idx_hit(apb_req.paddr, AMD_IDX_THR_LOW))
            prdata_next = {24'h0, thr_low_reg, 2'h0};
          if (idx_hit(apb_req.paddr, AMD_IDX_TIMERS))
            prdata_next = {24'h0, timers_reg};
          if (idx_hit(apb_req.paddr, AMD_IDX_AXIS))
            prdata_next = {26'h0, axis_reg[5:4], 1'b0, axis_reg[2:0]};
          if (idx_hit(apb_req.paddr, AMD_IDX_MIRROR))
            prdata_next = {24'h0, upset_reg, awake_reg, 6'h00};
          if (idx_hit(apb_req.paddr, AMD_IDX_AUX_CTRL))
            prdata_next = {22'h0, ctrl_reg};
          if (idx_hit(apb_req.paddr, AMD_IDX_ACT_THR))
            prdata_next = {19'h0, act_thr_reg};
          if (idx_hit(apb_req.paddr, AMD_IDX_INACT_THR_H))
            prdata_next = {25'h0, inact_h_reg};
          if (idx_hit(apb_req.paddr, AMD_IDX_IRQ_STAT))
            prdata_next = {29'h0, irq_stat_reg};
          if (idx_hit(apb_req.paddr, AMD_IDX_IRQ_MASK))
            prdata_next = {29'h0, irq_mask_reg};
        end
      end
      AMD_BUS_RESP: begin
        bus_state_next = AMD_BUS_IDLE;
      end
      default: begin
        bus_state_next = AMD_BUS_IDLE;
      end
    endcase
  end

  assign wr_acc = pready_reg & apb_req.psel & apb_req.penable & apb_req.pwrite
                  & mapped(apb_req.paddr);
  assign wd     = apb_req.pwdata;

  // Source select and detection enables
  always_comb begin
    if (ctrl_reg[AMD_CTL_TEMP_EN]) begin
      smp      = temp_sample;
      act_en   = ctrl_reg[AMD_CTL_TEMP_ACT];
      inact_en = ctrl_reg[AMD_CTL_TEMP_INACT];
    end else begin
      smp      = ext_sample;
      act_en   = ctrl_reg[AMD_CTL_EXT_EN] & ctrl_reg[AMD_CTL_EXT_ACT];
      inact_en = ctrl_reg[AMD_CTL_EXT_EN] & ctrl_reg[AMD_CTL_EXT_INACT];
    end
    mag       = magnitude(smp.code);
    inact_thr = {inact_h_reg, thr_low_reg};
  end

  // Run counters, events and awake state
  always_comb begin
    act_run_next   = act_run_reg;
    inact_run_next = inact_run_reg;
    act_evt_next   = 1'b0;
    inact_evt_next = 1'b0;
    if (!act_en)
      act_run_next = 4'h0;
    else if (smp.valid) begin
      if (mag > {1'b0, act_thr_reg}) begin
        act_run_next = run_step(act_run_reg);
        act_evt_next = run_done(act_run_reg, timers_reg[AMD_TMR_ACT_LSB +: 4]);
      end else
        act_run_next = 4'h0;
    end
    if (!inact_en)
      inact_run_next = 4'h0;
    else if (smp.valid) begin
      if (mag < {1'b0, inact_thr}) begin
        inact_run_next = run_step(inact_run_reg);
        inact_evt_next = run_done(inact_run_reg,
                                  timers_reg[AMD_TMR_INACT_LSB +: 4]);
      end else
        inact_run_next = 4'h0;
    end
    awake_next = awake_reg;
    if (ctrl_reg[AMD_CTL_MODE_LSB +: 2] == AMD_SEQ_DEFAULT)
      awake_next = 1'b1;
    else if (act_evt_next)
      awake_next = 1'b1;
    else if (inact_evt_next)
      awake_next = 1'b0;
  end

  // Register writes, upset flag and interrupt
  always_comb begin
    thr_low_next  = thr_low_reg;
    timers_next   = timers_reg;
    axis_next     = axis_reg;
    ctrl_next     = ctrl_reg;
    act_thr_next  = act_thr_reg;
    inact_h_next  = inact_h_reg;
    irq_mask_next = irq_mask_reg;
    irq_stat_next = irq_stat_reg;
    if (wr_acc) begin
      if (idx_hit(apb_req.paddr, AMD_IDX_THR_LOW))
        thr_low_next = wd[AMD_THR_LOW_LSB +: 6];
      if (idx_hit(apb_req.paddr, AMD_IDX_TIMERS))
        timers_next = wd[7:0];
      if (idx_hit(apb_req.paddr, AMD_IDX_AXIS))
        axis_next = {wd[AMD_TAP_AXIS_LSB +: 2], 1'b0, wd[2:0]};
      if (idx_hit(apb_req.paddr, AMD_IDX_AUX_CTRL))
        ctrl_next = wd[9:0];
      if (idx_hit(apb_req.paddr, AMD_IDX_ACT_THR))
        act_thr_next = wd[12:0];
      if (idx_hit(apb_req.paddr, AMD_IDX_INACT_THR_H))
        inact_h_next = wd[6:0];
      if (idx_hit(apb_req.paddr, AMD_IDX_IRQ_MASK))
        irq_mask_next = wd[2:0];
      if (idx_hit(apb_req.paddr, AMD_IDX_IRQ_STAT))
        irq_stat_next = irq_stat_reg & ~wd[2:0];
    end
    // Any write to a mapped register clears; a disturbance in the same cycle still wins
    unconf_next = soft_reset_done | (unconf_reg & ~wr_acc);
    upset_next  = reg_upset | soft_reset_done
                  | (~wr_acc & (upset_reg | unconf_reg));
    irq_set = '0;
    irq_set[AMD_IRQ_ACT]   = act_evt_next;
    irq_set[AMD_IRQ_INACT] = inact_evt_next;
    irq_set[AMD_IRQ_UPSET] = upset_next & ~upset_reg;
    irq_stat_next = irq_stat_next | irq_set;
    irq_next      = |(irq_stat_next & irq_mask_next);
    ext_on_next   = ctrl_next[AMD_CTL_EXT_EN] & ~ctrl_next[AMD_CTL_TEMP_EN];
    axis_en_next  = ~axis_next[2:0];
    // Reserved code 11 falls back to x
    tap_next      = (axis_next[5:4] == 2'h3) ? 2'h0 : axis_next[5:4];
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bus_state_reg <= AMD_BUS_IDLE;
      thr_low_reg   <= AMD_RST_THR_LOW[7:2];
      timers_reg    <= AMD_RST_TIMERS;
      axis_reg      <= AMD_RST_AXIS[5:0];
      ctrl_reg      <= AMD_RST_AUX_CTRL;
      act_thr_reg   <= AMD_RST_ACT_THR;
      inact_h_reg   <= AMD_RST_INACT_H;
      irq_stat_reg  <= AMD_RST_IRQ;
      irq_mask_reg  <= AMD_RST_IRQ;
      act_run_reg   <= 4'h0;
      inact_run_reg <= 4'h0;
      upset_reg     <= AMD_RST_MIRROR[AMD_UPSET_BIT];
      unconf_reg    <= 1'b1;
      awake_reg     <= AMD_RST_MIRROR[AMD_AWAKE_BIT];
      act_evt_reg   <= 1'b0;
      inact_evt_reg <= 1'b0;
      pready_reg    <= 1'b0;
      pslverr_reg   <= 1'b0;
      prdata_reg    <= 32'h0000_0000;
      irq_reg       <= 1'b0;
      ext_on_reg    <= 1'b0;
      axis_en_reg   <= 3'h7;
      tap_reg       <= 2'h0;
    end else if (clk_en) begin
      bus_state_reg <= bus_state_next;
      thr_low_reg   <= thr_low_next;
      timers_reg    <= timers_next;
      axis_reg      <= axis_next;
      ctrl_reg      <= ctrl_next;
      act_thr_reg   <= act_thr_next;
      inact_h_reg   <= inact_h_next;
      irq_stat_reg  <= irq_stat_next;
      irq_mask_reg  <= irq_mask_next;
      act_run_reg   <= act_run_next;
      inact_run_reg <= inact_run_next;
      upset_reg     <= upset_next;
      unconf_reg    <= unconf_next;
      awake_reg     <= awake_next;
      act_evt_reg   <= act_evt_next;
      inact_evt_reg <= inact_evt_next;
      pready_reg    <= pready_next;
      pslverr_reg   <= pslverr_next;
      prdata_reg    <= prdata_next;
      irq_reg       <= irq_next;
      ext_on_reg    <= ext_on_next;
      axis_en_reg   <= axis_en_next;
      tap_reg       <= tap_next;
    end
  end

  assign pready               = pready_reg;
  assign prdata               = prdata_reg;
  assign pslverr              = pslverr_reg;
  assign aux_activity_event   = act_evt_reg;
  assign aux_inactivity_event = inact_evt_reg;
  assign awake                = awake_reg;
  assign axis_check_enable    = axis_en_reg;
  assign tap_axis_select      = tap_reg;
  assign ext_converter_active = ext_on_reg;
  assign upset_error          = upset_reg;
  assign irq                  = irq_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence seq_read_taken(logic [7:0] idx);
    clk_en && bus_state_reg == AMD_BUS_IDLE && apb_req.psel && apb_req.penable
    && !apb_req.pwrite && idx_hit(apb_req.paddr, idx);
  endsequence

  AST_MAG_BREAKS_RUN: assert property (clk_en && inact_en && smp.valid
      && mag >= {1'b0, inact_thr} |=> inact_run_reg == 4'h0)
    else $error("inactivity run survived an above-threshold sample");
  AST_THR_RSVD_ZERO: assert property (seq_read_taken(AMD_IDX_THR_LOW)
      |=> pready && prdata[1:0] == 2'h0 && prdata[7:2] == thr_low_reg)
    else $error("threshold low read wrong");
  AST_INACT_AT_COUNT: assert property (clk_en && inact_evt_next
      && timers_reg[7:4] > 4'h1 |-> inact_run_reg == 4'(timers_reg[7:4] - 4'h1))
    else $error("inactivity event before count reached");
  AST_ACT_AT_COUNT: assert property (clk_en && act_evt_next
      && timers_reg[3:0] > 4'h1 |-> act_run_reg == 4'(timers_reg[3:0] - 4'h1))
    else $error("activity event before count reached");
  AST_TAP_CODE: assert property (clk_en |=> tap_axis_select != 2'h3
      && (axis_reg[5:4] == 2'h3 || tap_axis_select == axis_reg[5:4]))
    else $error("tap axis select mismatch");
  AST_AXIS_BLOCK: assert property (clk_en |=> axis_check_enable == ~axis_reg[2:0])
    else $error("axis check enable does not follow mask");
  AST_UPSET_SETS: assert property (clk_en && reg_upset |=> upset_error)
    else $error("upset not flagged");
  AST_UPSET_CLEARS: assert property (clk_en && wr_acc && !reg_upset
      && !soft_reset_done |=> !upset_error)
    else $error("write did not clear upset");
  AST_AWAKE_HELD: assert property (clk_en
      && ctrl_reg[9:8] == AMD_SEQ_DEFAULT |=> awake)
    else $error("awake not held in default mode");
  AST_MIRROR_READ: assert property (seq_read_taken(AMD_IDX_MIRROR)
      ##1 pready |-> prdata[5:0] == 6'h00 && prdata[31:8] == 24'h0)
    else $error("mirror read shows stray bits");
  AST_EVENT_NEEDS_EN: assert property ($rose(aux_activity_event)
      |-> $past(act_en))
    else $error("activity event while detection disabled");
  AST_EXT_OFF: assert property (clk_en && ctrl_next[AMD_CTL_TEMP_EN]
      |=> !ext_converter_active)
    else $error("external converter on with temperature enabled");

endmodule : amd_regs
